// ===== rtl/nta_pkg.sv
// Shared codes, states and timing constants of the NT activation controller.
package nta_pkg;
   // Downstream commands on the command/indication channel.
   localparam logic [3:0] CMD_DEACT_REQ         = 4'h0;
   localparam logic [3:0] CMD_SINGLE_PULSE_TEST = 4'h2;
   localparam logic [3:0] CMD_RESYNC_DOWN       = 4'h4;
   localparam logic [3:0] CMD_ACT_REQ_DOWN      = 4'h8;
   localparam logic [3:0] CMD_ACT_REQ_LOOP      = 4'ha;
   localparam logic [3:0] CMD_ACT_IND_DOWN      = 4'hc;
   localparam logic [3:0] CMD_ACT_IND_LOOP      = 4'he;
   localparam logic [3:0] CMD_DEACT_ACK_DOWN    = 4'hf;

   // Upstream indications.
   localparam logic [3:0] IND_CLOCK_REQUEST = 4'h0;
   localparam logic [3:0] IND_SIGNAL_LOST   = 4'h1;
   localparam logic [3:0] IND_FRAMING_LOST  = 4'h4;
   localparam logic [3:0] IND_ERROR         = 4'h6;
   localparam logic [3:0] IND_ACT_REQ_UP    = 4'h8;
   localparam logic [3:0] IND_ACT_IND_UP    = 4'hc;
   localparam logic [3:0] IND_DEACT_IND_UP  = 4'hf;

   // Reset value of the indication output.
   localparam logic [3:0] IND_RESET_VALUE = 4'h6;

   // Clock and line rates.
   localparam int unsigned CLK_HZ    = 40_000_000;
   localparam int unsigned RESYNC_HZ = 96_000;
   localparam int unsigned SINGLE_HZ = 2_000;
   localparam int unsigned MS_HZ     = 1_000;
   localparam int unsigned RESYNC_CYCLES = CLK_HZ / RESYNC_HZ;
   localparam int unsigned SINGLE_CYCLES = CLK_HZ / SINGLE_HZ;
   localparam int unsigned MS_CYCLES     = CLK_HZ / MS_HZ;

   // Deactivation times in milliseconds.
   localparam logic [5:0] INFO0_MS = 6'h10;
   localparam logic [5:0] TIMER_MS = 6'h20;

   // Bit positions in the synchronised pin vector.
   localparam int unsigned PIN_HW_RESET = 0;
   localparam int unsigned PIN_CONT     = 1;
   localparam int unsigned PIN_INFO0    = 2;
   localparam int unsigned PIN_INFO1    = 3;
   localparam int unsigned PIN_INFO3    = 4;
   localparam int unsigned PIN_RX_SYNC  = 5;
   localparam int unsigned PIN_LEVEL    = 6;
   localparam int unsigned PIN_COUNT    = 7;

   typedef enum logic [2:0] {
      TX_NONE   = 3'b000,
      TX_INFO2  = 3'b001,
      TX_INFO4  = 3'b010,
      TX_CONT   = 3'b011,
      TX_SINGLE = 3'b100
   } nta_tx_t;

   typedef enum logic [3:0] {
      ST_RESET       = 4'b0000,
      ST_DEACT       = 4'b0001,
      ST_CLK_REQ     = 4'b0010,
      ST_INFO1_DET   = 4'b0011,
      ST_PEND_ACT    = 4'b0100,
      ST_SYNC        = 4'b0101,
      ST_ACTIVE      = 4'b0110,
      ST_LOST_U      = 4'b0111,
      ST_PEND_DEACT  = 4'b1000,
      ST_UNACK       = 4'b1001,
      ST_TEST_CONT   = 4'b1010,
      ST_TEST_SINGLE = 4'b1011
   } nta_state_t;
endpackage : nta_pkg

// ===== rtl/nta_in_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module nta_in_sync #(
   parameter int unsigned WIDTH = 7
) (
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   input  wire logic [WIDTH-1:0] d_in,
   output var  logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire  [WIDTH-1:0] next_q = (stage3 & agree) | (q_out & ~agree);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta   <= '0;
         stage2 <= '0;
         stage3 <= '0;
         q_out  <= '0;
      end else begin
         meta   <= d_in;
         stage2 <= meta;
         stage3 <= stage2;
         q_out  <= next_q;
      end
   end
endmodule : nta_in_sync
`default_nettype wire

// ===== rtl/nta_rate_div.sv
// Enabled divider that gives a one-cycle tick every PERIOD clocks.
`timescale 1ns/1ps
`default_nettype none
module nta_rate_div #(
   parameter int unsigned PERIOD = 416
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic en_in,
   output var  logic tick_out
);
   localparam int unsigned W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);
   logic [W-1:0] count;
   wire          wrap = (count == LAST);
   wire  [W-1:0] next_count = wrap ? '0 : W'(count + 1'b1);

   // Restarting on disable keeps the first tick a full period away.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count    <= '0;
         tick_out <= 1'b0;
      end else begin
         count    <= en_in ? next_count : '0;
         tick_out <= en_in & wrap;
      end
   end
endmodule : nta_rate_div
`default_nettype wire

// ===== rtl/nta_act_fsm.sv
// NT-mode layer-1 activation and deactivation controller.
// Overview of operation
// (R1) Deactivate request 0000 is taken in any state and enters pending deactivation; the code ignores it while hardware reset or pulses pin is set.
// (R2) Resync command 0100 sends continuous alternating pulses at 96 kHz.
// (R3) Activate request 1000 sends INFO2 and waits in pending activation.
// (R4) Activate request loop 1010 sends INFO2 and closes test loop 2.
// (R5) Activate indication 1100 sends INFO4, activates, passes B and D through.
// (R6) Activate indication loop 1110 sends INFO4 and closes test loop 2.
// (R7) Single pulse test 0010 is unconditional, alternating pulses at 2 kHz; the code lets the hardware reset and pulses pins override it.
// (R8) After deactivation stay unacknowledged until acknowledge command 1111 arrives.
// (R9) Line activation from deactivated first reports clock request 0000.
// (R10) Report signal lost 0001 without level, framing lost 0100 unsynchronised.
// (R11) Error indication 0110 while hardware reset is active, also with pulses pin.
// (R12) On INFO1 report 1000 and wait for activate request before proceeding.
// (R13) After INFO3 keep INFO2, report 1100, wait for switch-through.
// (R14) Deactivated state transmits nothing and reports 1111.
// (R15) Pending deactivation ends after 16 ms of INFO0 or 32 ms timer.
// (R16) Activated with receiver sync lost falls back to INFO2.
// (R17) Indication is presented continuously; commands count only while received.
`timescale 1ns/1ps
`default_nettype none
module nta_act_fsm #(
   parameter int unsigned SINGLE_CYCLES = nta_pkg::SINGLE_CYCLES,
   parameter int unsigned MS_CYCLES     = nta_pkg::MS_CYCLES
) (
   input  wire logic           clk_in,
   input  wire logic           resetn_in,
   input  wire logic [3:0]     cmd_in,
   input  wire logic           cmd_valid_in,
   output var  logic [3:0]     ind_out,
   input  wire logic           hw_reset_pin_in,
   input  wire logic           continuous_pulse_pin_in,
   input  wire logic           info0_det_in,
   input  wire logic           info1_det_in,
   input  wire logic           info3_det_in,
   input  wire logic           rx_sync_in,
   input  wire logic           level_det_in,
   output var  nta_pkg::nta_tx_t tx_info_out,
   output var  logic           tx_mark_p_out,
   output var  logic           tx_mark_n_out,
   output var  logic           loop2_out,
   output var  logic           bd_transparent_out
);
   import nta_pkg::*;

   nta_state_t             state;
   nta_state_t             next_state;
   logic [PIN_COUNT-1:0]   pins;
   logic [5:0]             deact_ms;
   logic [5:0]             info0_ms;
   logic                   mark_pol;
   logic                   fast_tick;
   logic                   slow_tick;
   logic                   ms_tick;

   // Line-side status arrives from the transceiver, so it is synchronised.
   nta_in_sync #(.WIDTH(PIN_COUNT)) u_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .d_in      ({level_det_in, rx_sync_in, info3_det_in, info1_det_in,
                   info0_det_in, continuous_pulse_pin_in, hw_reset_pin_in}),
      .q_out     (pins)
   );

   wire rst_s   = pins[PIN_HW_RESET];
   wire cont_s  = pins[PIN_CONT];
   wire info0_s = pins[PIN_INFO0];
   wire info1_s = pins[PIN_INFO1];
   wire info3_s = pins[PIN_INFO3];
   wire sync_s  = pins[PIN_RX_SYNC];
   wire level_s = pins[PIN_LEVEL];

   // A command exists only in the cycles it is presented.
   wire cmd_take    = cmd_valid_in; // R17
   wire cmd_deact   = cmd_take && (cmd_in == CMD_DEACT_REQ);
   wire cmd_single  = cmd_take && (cmd_in == CMD_SINGLE_PULSE_TEST);
   wire cmd_resync  = cmd_take && (cmd_in == CMD_RESYNC_DOWN);
   wire cmd_ack     = cmd_take && (cmd_in == CMD_DEACT_ACK_DOWN);
   wire cmd_act_req = cmd_take && ((cmd_in == CMD_ACT_REQ_DOWN) ||
                                   (cmd_in == CMD_ACT_REQ_LOOP));
   wire cmd_act_ind = cmd_take && ((cmd_in == CMD_ACT_IND_DOWN) ||
                                   (cmd_in == CMD_ACT_IND_LOOP));
   wire cmd_loop    = (cmd_in == CMD_ACT_REQ_LOOP) ||
                      (cmd_in == CMD_ACT_IND_LOOP);

   wire info0_done = (info0_ms >= INFO0_MS);
   wire timer_done = (deact_ms >= TIMER_MS);

   function automatic logic [3:0] line_ind(input logic level);
      line_ind = level ? IND_FRAMING_LOST : IND_SIGNAL_LOST;
   endfunction : line_ind

   function automatic logic [3:0] ind_of(input nta_state_t s,
                                         input logic level,
                                         input logic sync);
      unique case (s)
         ST_RESET:      ind_of = IND_ERROR; // R11
         ST_CLK_REQ:    ind_of = IND_CLOCK_REQUEST; // R9
         ST_INFO1_DET:  ind_of = IND_ACT_REQ_UP; // R12
         ST_SYNC:       ind_of = IND_ACT_IND_UP; // R13
         ST_ACTIVE:     ind_of = sync ? IND_ACT_IND_UP : line_ind(level);
         ST_PEND_ACT,
         ST_LOST_U,
         ST_PEND_DEACT: ind_of = line_ind(level); // R10
         default:       ind_of = IND_DEACT_IND_UP; // R14
      endcase
   endfunction : ind_of

   function automatic nta_tx_t tx_of(input nta_state_t s, input logic sync);
      unique case (s)
         ST_PEND_ACT,
         ST_SYNC:        tx_of = TX_INFO2; // R13
         ST_ACTIVE:      tx_of = sync ? TX_INFO4 : TX_INFO2; // R16
         ST_LOST_U,
         ST_TEST_CONT:   tx_of = TX_CONT; // R2
         ST_TEST_SINGLE: tx_of = TX_SINGLE; // R7
         default:        tx_of = TX_NONE; // R14
      endcase
   endfunction : tx_of

   always_comb begin
      next_state = state;
      if (rst_s) begin
         next_state = ST_RESET; // R11
      end else if (cont_s) begin
         next_state = ST_TEST_CONT;
      end else if (cmd_deact) begin
         next_state = ST_PEND_DEACT; // R1
      end else if (cmd_single) begin
         next_state = ST_TEST_SINGLE; // R7
      end else begin
         unique case (state)
            ST_RESET: next_state = ST_DEACT;
            ST_DEACT: begin
               if (cmd_act_req) next_state = ST_PEND_ACT; // R3
               else if (info1_s) next_state = ST_CLK_REQ; // R9
            end
            ST_CLK_REQ: begin
               if (cmd_act_req) next_state = ST_PEND_ACT;
               else if (!info1_s) next_state = ST_DEACT;
               else if (ms_tick) next_state = ST_INFO1_DET;
            end
            ST_INFO1_DET: begin
               if (cmd_act_req) next_state = ST_PEND_ACT; // R12
               else if (!info1_s) next_state = ST_DEACT;
            end
            ST_PEND_ACT: begin
               if (cmd_resync) next_state = ST_LOST_U; // R2
               else if (info3_s && sync_s) next_state = ST_SYNC; // R13
            end
            ST_SYNC: begin
               if (cmd_resync) next_state = ST_LOST_U;
               else if (cmd_act_ind) next_state = ST_ACTIVE; // R5
               else if (!sync_s) next_state = ST_PEND_ACT;
            end
            ST_ACTIVE: begin
               if (cmd_resync) next_state = ST_LOST_U;
            end
            ST_LOST_U: begin
               if (cmd_act_ind) next_state = ST_ACTIVE;
               else if (cmd_act_req) next_state = ST_PEND_ACT;
            end
            ST_PEND_DEACT: begin
               if (info0_done || timer_done) next_state = ST_UNACK; // R15
            end
            ST_UNACK: begin
               if (cmd_ack) next_state = ST_DEACT; // R8
            end
            ST_TEST_CONT: next_state = ST_DEACT;
            ST_TEST_SINGLE: begin
               if (cmd_ack) next_state = ST_DEACT;
            end
            default: next_state = ST_RESET;
         endcase
      end
   end

   // Loop 2 follows the last activate command taken on the activation path.
   wire on_act_path = (next_state == ST_PEND_ACT) || (next_state == ST_SYNC) ||
                      (next_state == ST_ACTIVE);
   wire loop_cmd    = (cmd_act_req && (next_state == ST_PEND_ACT)) ||
                      (cmd_act_ind && (next_state == ST_ACTIVE));
   wire next_loop   = on_act_path && (loop_cmd ? cmd_loop : loop2_out); // R4 R6
   wire next_bd     = (next_state == ST_ACTIVE) && sync_s; // R5

   wire in_pend = (state == ST_PEND_DEACT);
   wire [5:0] next_deact_ms = !in_pend ? 6'h00 :
                              ms_tick ? 6'(deact_ms + 6'h01) : deact_ms;
   wire [5:0] next_info0_ms = (!in_pend || !info0_s) ? 6'h00 :
                              ms_tick ? 6'(info0_ms + 6'h01) : info0_ms;

   wire ms_en = in_pend || (state == ST_CLK_REQ);
   wire pulse_tick = (tx_info_out == TX_CONT) ? fast_tick :
                     (tx_info_out == TX_SINGLE) ? slow_tick : 1'b0;

   nta_rate_div #(.PERIOD(RESYNC_CYCLES)) u_fast (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .en_in     (tx_info_out == TX_CONT),
      .tick_out  (fast_tick)
   );

   nta_rate_div #(.PERIOD(SINGLE_CYCLES)) u_slow (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .en_in     (tx_info_out == TX_SINGLE),
      .tick_out  (slow_tick)
   );

   nta_rate_div #(.PERIOD(MS_CYCLES)) u_ms (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .en_in     (ms_en),
      .tick_out  (ms_tick)
   );

   // Outputs are taken from the next state so they never lag the state.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state              <= ST_RESET;
         ind_out            <= IND_RESET_VALUE; // R11
         tx_info_out        <= TX_NONE;
         loop2_out          <= 1'b0;
         bd_transparent_out <= 1'b0;
         deact_ms           <= 6'h00;
         info0_ms           <= 6'h00;
      end else begin
         state              <= next_state;
         ind_out            <= ind_of(next_state, level_s, sync_s); // R17
         tx_info_out        <= tx_of(next_state, sync_s);
         loop2_out          <= next_loop;
         bd_transparent_out <= next_bd;
         deact_ms           <= next_deact_ms;
         info0_ms           <= next_info0_ms;
      end
   end

   // Alternating marks keep the line free of DC in both test patterns.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mark_pol      <= 1'b0;
         tx_mark_p_out <= 1'b0;
         tx_mark_n_out <= 1'b0;
      end else begin
         mark_pol      <= mark_pol ^ pulse_tick;
         tx_mark_p_out <= pulse_tick & mark_pol; // R2 R7
         tx_mark_n_out <= pulse_tick & ~mark_pol;
      end
   end

   localparam int RESYNC_WAIT = 420;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   wire quiet = !rst_s && !cont_s;

   AST_DEACT_REQ: assert property ( // R1
      (cmd_deact && quiet) |=> (state == ST_PEND_DEACT))
      else $error("deactivate request not taken");
   AST_RESYNC_PULSES: assert property ( // R2
      ((state == ST_LOST_U) && (tx_info_out == TX_CONT) && quiet &&
      !cmd_take) [*8] |-> ##[1:RESYNC_WAIT]
      (tx_mark_p_out || tx_mark_n_out || state != ST_LOST_U))
      else $error("no resync pulse seen");
   AST_ACT_REQ: assert property ( // R3
      (state == ST_DEACT && cmd_take && cmd_in == CMD_ACT_REQ_DOWN && quiet)
      |=> (state == ST_PEND_ACT) && (tx_info_out == TX_INFO2) && !loop2_out)
      else $error("activate request did not start info2");
   AST_LOOP_CLOSE: assert property ( // R4
      (state == ST_DEACT && cmd_take && cmd_in == CMD_ACT_REQ_LOOP && quiet)
      |=> loop2_out && (tx_info_out == TX_INFO2))
      else $error("loop activate did not close loop 2");
   AST_SWITCH_THROUGH: assert property ( // R5
      (state == ST_SYNC && cmd_act_ind && sync_s && quiet)
      |=> (state == ST_ACTIVE) && bd_transparent_out &&
          (tx_info_out == TX_INFO4))
      else $error("switch-through did not activate");
   AST_SINGLE_TEST: assert property ( // R7
      (cmd_single && quiet) |=> (tx_info_out == TX_SINGLE))
      else $error("single pulse test not entered");
   AST_UNACK_HOLD: assert property ( // R8
      (state == ST_UNACK && quiet && !cmd_ack && !cmd_deact && !cmd_single)
      |=> (state == ST_UNACK) && (ind_out == IND_DEACT_IND_UP))
      else $error("left unacknowledged state without acknowledge");
   AST_RESET_ERROR: assert property ( // R11
      rst_s |=> (ind_out == IND_ERROR) && (tx_info_out == TX_NONE))
      else $error("error indication missing during reset");
   AST_INFO1_WAIT: assert property ( // R12
      (state == ST_INFO1_DET) |-> (ind_out == IND_ACT_REQ_UP) &&
      (tx_info_out == TX_NONE))
      else $error("info1 indication wrong");
   AST_DEACT_TIMEOUT: assert property ( // R15
      (in_pend && timer_done && quiet && !cmd_take) |=> (state == ST_UNACK))
      else $error("deactivation timer expiry ignored");
   AST_SYNC_FALLBACK: assert property ( // R16
      (state == ST_ACTIVE && next_state == ST_ACTIVE && !sync_s)
      |=> (tx_info_out == TX_INFO2) && !bd_transparent_out)
      else $error("no info2 fallback on sync loss");

   COV_ACTIVE: cover property (state == ST_SYNC ##1 state == ST_ACTIVE);
   COV_UNACK: cover property (state == ST_PEND_DEACT ##1 state == ST_UNACK);
   COV_SINGLE_MARK: cover property (state == ST_TEST_SINGLE && tx_mark_n_out);
endmodule : nta_act_fsm
`default_nettype wire

// ===== dv/nta_upstream_model.sv
// Upstream transmission device model on the command/indication channel.
`timescale 1ns/1ps
`default_nettype none
module nta_upstream_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] ind_in,
   output var  logic [3:0] cmd_out,
   output var  logic       cmd_valid_out
);
   logic [3:0] seen_ind;

   initial begin
      cmd_out       = 4'h5;
      cmd_valid_out = 1'b0;
   end

   // The indication is repeated every frame, so it is sampled each clock.
   always @(posedge clk_in) begin
      seen_ind <= ind_in;
   end

   // One command a call, valid for exactly one clock. The code is inverted
   // after release so a stale value never looks like a fresh command.
   // The bench uses it for every command it sends, deactivate, test and resync included.
   task automatic send(input logic [3:0] code);
      @(negedge clk_in);
      cmd_out       = code;
      cmd_valid_out = 1'b1;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      cmd_out       = ~code;
   endtask : send
endmodule : nta_upstream_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench of the NT activation controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
   err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
   end end
module tb_top;
   import nta_pkg::*;
   localparam int unsigned SC = 50;
   localparam int unsigned MC = 20;
   logic             clk_in          = 1'b0;
   logic             resetn_in       = 1'b0;
   logic             hw_reset        = 1'b0;
   logic             cont            = 1'b0;
   logic             info0           = 1'b0;
   logic             info1           = 1'b0;
   logic             info3           = 1'b0;
   logic             sync            = 1'b0;
   logic             level           = 1'b0;
   logic [3:0]       cmd_in;
   logic             cmd_valid_in;
   logic [3:0]       ind_out;
   nta_tx_t          tx_info_out;
   logic             tx_mark_p_out;
   logic             tx_mark_n_out;
   logic             loop2_out;
   logic             bd_transparent_out;
   int               err_count       = 0;
   int               total_checks    = 0;

   always #12.5 clk_in = ~clk_in;

   nta_act_fsm #(.SINGLE_CYCLES(SC), .MS_CYCLES(MC)) DUT (
      .clk_in                  (clk_in),
      .resetn_in               (resetn_in),
      .cmd_in                  (cmd_in),
      .cmd_valid_in            (cmd_valid_in),
      .ind_out                 (ind_out),
      .hw_reset_pin_in         (hw_reset),
      .continuous_pulse_pin_in (cont),
      .info0_det_in            (info0),
      .info1_det_in            (info1),
      .info3_det_in            (info3),
      .rx_sync_in              (sync),
      .level_det_in            (level),
      .tx_info_out             (tx_info_out),
      .tx_mark_p_out           (tx_mark_p_out),
      .tx_mark_n_out           (tx_mark_n_out),
      .loop2_out               (loop2_out),
      .bd_transparent_out      (bd_transparent_out)
   );

   nta_upstream_model u_upstream (
      .clk_in        (clk_in),
      .ind_in        (ind_out),
      .cmd_out       (cmd_in),
      .cmd_valid_out (cmd_valid_in)
   );

   task automatic cyc(input int unsigned n);
      repeat (n) @(negedge clk_in);
   endtask : cyc

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   // Measures the spacing of two marks and their alternation.
   task automatic pulse_gap(input int unsigned gap);
      int unsigned n;
      logic        was_n;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (!(tx_mark_p_out | tx_mark_n_out) && n < 2000);
      was_n = tx_mark_n_out;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (!(tx_mark_p_out | tx_mark_n_out) && n < 2000);
      `CHK(n, gap)
      `CHK(tx_mark_p_out, was_n)
   endtask : pulse_gap

   task automatic t_reset();
      cyc(2);
      `CHK(ind_out, IND_ERROR)
      cyc(14);
      resetn_in = 1'b1;
      cyc(4);
      `CHK(ind_out, IND_DEACT_IND_UP)
      `CHK(tx_info_out, TX_NONE)
   endtask : t_reset

   // Both pins together must still give the error code.
   task automatic t_pins();
      hw_reset = 1'b1;
      cont     = 1'b1;
      cyc(8);
      `CHK(ind_out, IND_ERROR)
      hw_reset = 1'b0;
      cont     = 1'b0;
      cyc(10);
      `CHK(ind_out, IND_DEACT_IND_UP)
      cont = 1'b1;
      cyc(8);
      `CHK(tx_info_out, TX_CONT)
      `CHK(ind_out, IND_DEACT_IND_UP)
      cont = 1'b0;
      cyc(10);
      `CHK(tx_info_out, TX_NONE)
      `CHK(ind_out, IND_DEACT_IND_UP)
   endtask : t_pins

   task automatic t_line_act();
      info1 = 1'b1;
      cyc(8);
      `CHK(ind_out, IND_CLOCK_REQUEST)
      cyc(2 * MC);
      `CHK(ind_out, IND_ACT_REQ_UP)
      `CHK(tx_info_out, TX_NONE)
      info1 = 1'b0;
      u_upstream.send(CMD_ACT_REQ_DOWN);
      cyc(1);
      `CHK(tx_info_out, TX_INFO2)
      `CHK(ind_out, IND_SIGNAL_LOST)
      level = 1'b1;
      cyc(8);
      `CHK(ind_out, IND_FRAMING_LOST)
      info3 = 1'b1;
      sync  = 1'b1;
      cyc(8);
      `CHK(ind_out, IND_ACT_IND_UP)
      `CHK(u_upstream.seen_ind, IND_ACT_IND_UP)
      `CHK(tx_info_out, TX_INFO2)
      u_upstream.send(CMD_ACT_IND_DOWN);
      cyc(1);
      `CHK(tx_info_out, TX_INFO4)
      `CHK(bd_transparent_out, 1'b1)
      u_upstream.send(CMD_ACT_IND_LOOP);
      cyc(1);
      `CHK(loop2_out, 1'b1)
      `CHK(tx_info_out, TX_INFO4)
      sync = 1'b0;
      cyc(8);
      `CHK(tx_info_out, TX_INFO2)
   endtask : t_line_act

   // Quiet line for 16 ms ends the wait; new activation refused until ack.
   task automatic t_deact();
      info3 = 1'b0;
      info0 = 1'b1;
      cyc(6);
      u_upstream.send(CMD_DEACT_REQ);
      cyc(1);
      `CHK(tx_info_out, TX_NONE)
      `CHK(ind_out, IND_FRAMING_LOST)
      cyc(14 * MC);
      `CHK(ind_out, IND_FRAMING_LOST)
      cyc(6 * MC);
      `CHK(ind_out, IND_DEACT_IND_UP)
      info0 = 1'b0;
      u_upstream.send(CMD_ACT_REQ_DOWN);
      cyc(1);
      `CHK(tx_info_out, TX_NONE)
      u_upstream.send(CMD_DEACT_ACK_DOWN);
      u_upstream.send(CMD_ACT_REQ_LOOP);
      cyc(1);
      `CHK(tx_info_out, TX_INFO2)
      `CHK(loop2_out, 1'b1)
   endtask : t_deact

   // Without a quiet line only the 32 ms timer ends the wait.
   task automatic t_timer();
      u_upstream.send(CMD_DEACT_REQ);
      cyc(30 * MC);
      `CHK(ind_out, IND_FRAMING_LOST)
      cyc(6 * MC);
      `CHK(ind_out, IND_DEACT_IND_UP)
      u_upstream.send(CMD_DEACT_ACK_DOWN);
   endtask : t_timer

   task automatic t_pulses();
      u_upstream.send(CMD_SINGLE_PULSE_TEST);
      cyc(1);
      `CHK(tx_info_out, TX_SINGLE)
      pulse_gap(SC);
      u_upstream.send(CMD_DEACT_ACK_DOWN);
      u_upstream.send(CMD_ACT_REQ_DOWN);
      u_upstream.send(CMD_RESYNC_DOWN);
      cyc(1);
      `CHK(tx_info_out, TX_CONT)
      pulse_gap(RESYNC_CYCLES);
   endtask : t_pulses

   initial begin
      t_reset();
      t_pins();
      t_line_act();
      t_deact();
      t_timer();
      t_pulses();
      end_of_test();
   end

   // The whole run needs about 2200 clocks; this allows ample margin.
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
